/* File: pkg/axr_consts.svh */
// Constants for the auxiliary result register bank
`ifndef AXR_CONSTS_SVH
`define AXR_CONSTS_SVH
`define AXR_NUM_CH 5
`define AXR_CODE_W 14
`define AXR_RES_W 16
`define AXR_CODE_LSB 2
`define AXR_IDX_CH1 8'h5A
`define AXR_IDX_CH2 8'h5B
`define AXR_IDX_CH3 8'h5C
`define AXR_IDX_CH4 8'h5D
`define AXR_IDX_CH5 8'h5E
`define AXR_IDX_CTRL 8'h70
`define AXR_IDX_STAT 8'h71
`define AXR_RES_RST 16'h0000
`define AXR_WORD_ZERO 32'h0000_0000
`define AXR_HTRANS_NONSEQ 2'h2
`define AXR_HTRANS_SEQ 2'h3
`define AXR_HSIZE_WORD 3'h2
`endif

/* File: pkg/axr_pkg.sv */
// Types for the auxiliary result register bank
package axr_pkg;
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic [13:0] code;
   } axr_meas_t;
   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic [31:0] hwdata;
      logic hready;
   } axr_ahb_req_t;
   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } axr_ahb_rsp_t;
   typedef enum logic {AXR_IDLE, AXR_DATA} axr_phase_t;
endpackage

/* File: hdl/axr_aux_result_bank.sv */
// Auxiliary result register bank with an AHB-Lite register slave
`timescale 1ns/1ps
`include "axr_consts.svh"

// Functional notes
// - each result shows its 14-bit code in bits 15 to 2.
// - channel not configured as auxiliary input reads all zero.
// - scan skipping a configured but disabled channel keeps old result.
// - results are read-only and updated when an enabled measurement of a configured channel completes.
// - code scaled to supply or reference; reference mode shown in status.
module axr_aux_result_bank
   import axr_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire axr_meas_t measIn,
   input wire logic [4:0] sidePortConfig,
   input wire logic [4:0] sideMeasureEnable,
   input wire logic refAbsolute,
   input wire axr_ahb_req_t ahbReq,
   output axr_ahb_rsp_t ahbRsp
);
   //------------------------------------------------------------
   // Result storage
   //------------------------------------------------------------
   logic [`AXR_CODE_W-1:0] code_q [`AXR_NUM_CH];
   logic [`AXR_CODE_W-1:0] code_d [`AXR_NUM_CH];
   logic [`AXR_NUM_CH-1:0] fresh_q;
   logic [`AXR_NUM_CH-1:0] fresh_d;
   logic [`AXR_NUM_CH-1:0] hit;
   logic clrFresh;

   genvar gi;
   generate
      for (gi = 0; gi < `AXR_NUM_CH; gi++) begin : g_ch
         // Only an enabled measurement of a configured port lands
         assign hit[gi] = measIn.valid && (measIn.chan == 3'(gi + 1))
                          && sidePortConfig[gi] && sideMeasureEnable[gi];
         always_comb begin
            code_d[gi] = hit[gi] ? measIn.code : code_q[gi];
            fresh_d[gi] = hit[gi] | (fresh_q[gi] & ~clrFresh);
         end
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               code_q[gi] <= `AXR_CODE_W'(`AXR_RES_RST);
               fresh_q[gi] <= 1'b0;
            end else if (clkEn) begin
               code_q[gi] <= code_d[gi];
               fresh_q[gi] <= fresh_d[gi];
            end
         end
      end
   endgenerate

   //------------------------------------------------------------
   // Control register
   //------------------------------------------------------------
   logic autoClr_q;
   logic autoClr_d;

   //------------------------------------------------------------
   // AHB-Lite slave
   //------------------------------------------------------------
   axr_phase_t phase_q;
   axr_phase_t phase_d;
   logic [7:0] idx_q;
   logic [7:0] idx_d;
   logic wr_q;
   logic wr_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic addrPhase;
   logic [7:0] aIdx;
   logic [15:0] resWord;
   logic [2:0] selCh;
   logic selHit;

   assign addrPhase = ahbReq.hsel && ahbReq.hready
                      && (ahbReq.htrans == `AXR_HTRANS_NONSEQ
                          || ahbReq.htrans == `AXR_HTRANS_SEQ);
   assign aIdx = ahbReq.haddr[9:2];

   always_comb begin
      selHit = 1'b1;
      selCh = 3'h0;
      case (aIdx)
         `AXR_IDX_CH1: selCh = 3'h0;
         `AXR_IDX_CH2: selCh = 3'h1;
         `AXR_IDX_CH3: selCh = 3'h2;
         `AXR_IDX_CH4: selCh = 3'h3;
         `AXR_IDX_CH5: selCh = 3'h4;
         default: selHit = 1'b0;
      endcase
      // Unconfigured ports read zero; code left-justified, low bits zero
      if (selHit && sidePortConfig[selCh]) begin
         resWord = {code_q[selCh], 2'b00};
      end else begin
         resWord = `AXR_RES_RST;
      end
   end

   always_comb begin
      phase_d = phase_q;
      idx_d = idx_q;
      wr_d = wr_q;
      rdata_d = rdata_q;
      autoClr_d = autoClr_q;
      clrFresh = 1'b0;
      if (phase_q == AXR_DATA && wr_q && idx_q == `AXR_IDX_CTRL) begin
         autoClr_d = ahbReq.hwdata[0];
      end
      case (phase_q)
         AXR_IDLE: ;
         AXR_DATA: phase_d = AXR_IDLE;
         default: phase_d = AXR_IDLE;
      endcase
      if (addrPhase) begin
         phase_d = AXR_DATA;
         idx_d = aIdx;
         wr_d = ahbReq.hwrite;
         rdata_d = `AXR_WORD_ZERO;
         if (!ahbReq.hwrite) begin
            if (selHit) begin
               rdata_d = {16'h0000, resWord};
            end else if (aIdx == `AXR_IDX_CTRL) begin
               rdata_d = {31'h0000_0000, autoClr_q};
            end else if (aIdx == `AXR_IDX_STAT) begin
               // Fresh flags and reference mode
               rdata_d = {26'h000_0000, refAbsolute, fresh_q};
               clrFresh = autoClr_q;
            end
         end
      end
   end

   // Writes to result registers fall through with no effect
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phase_q <= AXR_IDLE;
         idx_q <= 8'h00;
         wr_q <= 1'b0;
         rdata_q <= `AXR_WORD_ZERO;
         autoClr_q <= 1'b0;
      end else if (clkEn) begin
         phase_q <= phase_d;
         idx_q <= idx_d;
         wr_q <= wr_d;
         rdata_q <= rdata_d;
         autoClr_q <= autoClr_d;
      end
   end

   assign ahbRsp.hrdata = rdata_q;
   assign ahbRsp.hreadyout = 1'b1;
   assign ahbRsp.hresp = 1'b0;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   chk_result_update: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && hit[0] |=> code_q[0] == $past(measIn.code))
      else $error("channel one result not updated");
   chk_skip_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && !hit[1] |=> $stable(code_q[1]))
      else $error("channel two result changed without enabled measurement");
   chk_unconfig_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && addrPhase && !ahbReq.hwrite && aIdx == `AXR_IDX_CH3 && !sidePortConfig[2]
      |=> rdata_q == `AXR_WORD_ZERO)
      else $error("unconfigured channel read not zero");
   chk_left_just: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && addrPhase && !ahbReq.hwrite && aIdx == `AXR_IDX_CH1 && sidePortConfig[0]
      |=> rdata_q[15:2] == $past(code_q[0]) && rdata_q[1:0] == 2'b00)
      else $error("result not left justified");
   chk_write_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && phase_q == AXR_DATA && wr_q && !hit[3] |=> $stable(code_q[3]))
      else $error("write altered a result");
   chk_ref_status: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && addrPhase && !ahbReq.hwrite && aIdx == `AXR_IDX_STAT
      |=> rdata_q[5] == $past(refAbsolute))
      else $error("reference mode not reported");
   chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && addrPhase && !ahbReq.hwrite && !selHit && aIdx != `AXR_IDX_CTRL
      && aIdx != `AXR_IDX_STAT |=> rdata_q == `AXR_WORD_ZERO)
      else $error("unmapped read not zero");
   chk_fresh_set: assert property (@(posedge core_clk) disable iff (!nrst)
      clkEn && hit[4] |=> fresh_q[4])
      else $error("fresh flag lost");
   cov_update: cover property (@(posedge core_clk) disable iff (!nrst) hit[0]);
   cov_skip: cover property (@(posedge core_clk) disable iff (!nrst)
      measIn.valid && sidePortConfig[1] && !sideMeasureEnable[1] && measIn.chan == 3'h2);
   cov_read: cover property (@(posedge core_clk) disable iff (!nrst)
      addrPhase && !ahbReq.hwrite && selHit);
endmodule // axr_aux_result_bank

/* File: tb/aux_result_registers_bench.sv */
// Self-checking bench for the auxiliary result register bank
`timescale 1ns/1ps
`include "axr_consts.svh"
module aux_result_registers_bench
   import axr_pkg::*;
;
   logic core_clk, nrst, clkEn, refAbsolute;
   logic [4:0] sidePortConfig, sideMeasureEnable;
   axr_meas_t measIn;
   axr_ahb_req_t req;
   axr_ahb_rsp_t ahbRsp;
   logic [31:0] rd;
   logic [13:0] cur [1:5];
   int failures, num_checks;
   axr_aux_result_bank u_dut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
      .measIn(measIn), .sidePortConfig(sidePortConfig),
      .sideMeasureEnable(sideMeasureEnable), .refAbsolute(refAbsolute),
      .ahbReq({req[$bits(req)-1:1], ahbRsp.hreadyout}), .ahbRsp(ahbRsp));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ------------------------------------------------------------
   // Bus and check helpers
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ahbRsp.hreadyout !== 1'b1 && n < 50);
      if (ahbRsp.hreadyout !== 1'b1) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      req.haddr <= {22'h0, idx, 2'h0};
      req.htrans <= `AXR_HTRANS_NONSEQ;
      req.hwrite <= wr;
      req.hsize <= `AXR_HSIZE_WORD;
      req.hsel <= 1'b1;
      wait_rdy();
      req.htrans <= 2'h0;
      req.hwdata <= wd;
      wait_rdy();
      rd = ahbRsp.hrdata;
   endtask
   task automatic rdchk(input int ch, input logic [31:0] exp);
      bus(1'b0, 8'(`AXR_IDX_CH1 + ch - 1), 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic meas(input int ch, input logic [13:0] code);
      measIn <= '{1'b1, 3'(ch), code};
      cur[ch] = code;
      @(posedge core_clk);
      measIn.valid <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_update();
      for (int ch = 1; ch <= 5; ch++) begin
         rdchk(ch, 32'h0000_0000);
         meas(ch, 14'(14'h3FFF - ch));
         rdchk(ch, {16'h0000, cur[ch], 2'h0});
      end
   endtask
   task automatic t_hold();
      sideMeasureEnable <= 5'h1D;
      meas(2, 14'h1234);
      cur[2] = 14'(14'h3FFF - 2);
      rdchk(2, {16'h0000, cur[2], 2'h0});
      bus(1'b1, `AXR_IDX_CH2, 32'hFFFF_FFFF);
      rdchk(2, {16'h0000, cur[2], 2'h0});
      rdchk(8'h28, 32'h0000_0000);
      sideMeasureEnable <= 5'h1F;
      meas(2, 14'h0001);
      rdchk(2, 32'h0000_0004);
   endtask
   task automatic t_unconf();
      sidePortConfig <= 5'h1B;
      @(posedge core_clk);
      rdchk(3, 32'h0000_0000);
      meas(3, 14'h2222);
      cur[3] = 14'(14'h3FFF - 3);
      sidePortConfig <= 5'h1F;
      @(posedge core_clk);
      rdchk(3, {16'h0000, cur[3], 2'h0});
   endtask
   task automatic t_scale();
      refAbsolute <= 1'b1;
      bus(1'b0, `AXR_IDX_STAT, 32'h0000_0000);
      chk({31'h0, rd[5]}, 32'h0000_0001);
      refAbsolute <= 1'b0;
      bus(1'b0, `AXR_IDX_STAT, 32'h0000_0000);
      chk({31'h0, rd[5]}, 32'h0000_0000);
   endtask
   task automatic t_fresh();
      bus(1'b0, `AXR_IDX_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_001F);
      chk({31'h0, ahbRsp.hresp}, 32'h0000_0000);
      bus(1'b1, `AXR_IDX_CTRL, 32'h0000_0001);
      bus(1'b0, `AXR_IDX_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      bus(1'b0, `AXR_IDX_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_001F);
      bus(1'b0, `AXR_IDX_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      meas(5, 14'h0ABC);
      bus(1'b0, `AXR_IDX_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0010);
   endtask
   initial begin
      nrst = 1'b0;
      clkEn = 1'b1;
      refAbsolute = 1'b0;
      sidePortConfig = 5'h1F;
      sideMeasureEnable = 5'h1F;
      measIn = '0;
      req = '0;
      failures = 0;
      num_checks = 0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_update();
      t_hold();
      t_unconf();
      t_scale();
      t_fresh();
      stop_test();
   end
endmodule // aux_result_registers_bench
